// [rtl/bcd_counter_defines.vh]
// Constants shared by the BCD counter bank: register map, fields, codes.
// Assumes inclusion by bare name from the rtl folder.
`ifndef BCD_COUNTER_DEFINES_VH
`define BCD_COUNTER_DEFINES_VH

// Register byte offsets on the AXI4-Lite slave
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_INSPECT_SLOT 8'h08
`define REG_INSPECT_DATA 8'h0C
`define REG_EXEC_COUNT 8'h10

// Control register fields and reset value
`define CTRL_ENABLE_BIT 0
`define CTRL_RESET 32'h0000_0001

// Status register sticky bits, write one to clear
`define STAT_ERROR_BIT 0
`define STAT_CONFLICT_BIT 1

// Inspect data field positions
`define INSP_CLAIMED_BIT 16
`define INSP_FLAG_BIT 17
`define INSP_MODE_BIT 18

// Counter operation codes on the exec_mode input
`define MODE_DOWN 1'b0
`define MODE_REVERSIBLE 1'b1

// AXI response codes
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

// Counter geometry
`define BCD_DIGITS 4
`define SLOT_COUNT 512
`define SLOT_BITS 9
`define PV_ZERO 16'h0000

`endif

// [rtl/bcd_step.v]
// Four-digit BCD increment or decrement by one, plus validity and zero test.
// Purely combinational; the caller picks which result to keep.
module bcd_step #(
  parameter DIGITS = 4
) (
  input wire [4*DIGITS-1:0] value,
  input wire down,
  output wire [4*DIGITS-1:0] result,
  output wire is_bcd,
  output wire is_zero
);

  // Carry or borrow ripples from the lowest digit
  wire [DIGITS:0] carry;
  wire [DIGITS-1:0] digit_ok;

  assign carry[0] = 1'b1;

  genvar i;
  generate
    for (i = 0; i < DIGITS; i = i + 1) begin : g_digit
      wire [3:0] d = value[4*i+3:4*i];
      // Wrap digit at 9 going up, at 0 going down
      wire wrap = down ? (d == 4'h0) : (d == 4'h9);
      wire [3:0] stepped = down ? (wrap ? 4'h9 : d - 4'h1) : (wrap ? 4'h0 : d + 4'h1);
      assign result[4*i+3:4*i] = carry[i] ? stepped : d;
      assign carry[i+1] = carry[i] & wrap;
      assign digit_ok[i] = (d <= 4'h9);
    end
  endgenerate

  // A non-BCD digit still steps, but the caller reports it
  assign is_bcd = &digit_ok;
  assign is_zero = (value == {4*DIGITS{1'b0}});

endmodule

// [rtl/bcd_updown_counter.v]
// Bank of four-digit BCD counters, evaluated one slot per execution strobe.
// Assumes a sequencer that presents slot, mode and input levels with a strobe,
// and an AXI4-Lite master for control and inspection. One clock, sync reset.
//
// How it works
// - Down mode: rising count pulse decrements count
// - Down mode: reset rise reloads preset, holds count
// - Down mode: flag set at zero until reset
// - Counts are four BCD digits, max 9999
// - Own flag as reset reloads and resumes
// - Flag may feed another slot's count input
// - 512 slots; one instance per slot
// - Reversible mode: circular count zero to preset
// - Reversible: rising up input adds one
// - Reversible: rising down input subtracts one
// - Reversible: both or neither rising, no change
// - Reversible: below zero loads preset, sets flag
// - Reversible: past preset clears count, sets flag
// - Reversible: reset rise clears count
// - Reversible: no counting while reset on
// - Counts survive interlock and power loss
// - Bad preset or operand raises error, continues
//
// Added by the designer: the placing of the registers and register access over AXI4-Lite.
`include "bcd_counter_defines.vh"

module bcd_updown_counter #(
  parameter SLOTS = `SLOT_COUNT,
  parameter SLOT_W = `SLOT_BITS,
  parameter DIGITS = `BCD_DIGITS
) (
  input wire clk_sys,
  input wire rstn,
  // Sequencer execution port
  input wire exec_strobe,
  input wire [SLOT_W-1:0] exec_slot,
  input wire exec_mode,
  input wire count_pulse_input,
  input wire count_up_input,
  input wire count_down_input,
  input wire count_reset_input,
  input wire [4*DIGITS-1:0] preset_limit,
  input wire operand_fault,
  output reg exec_done,
  output reg done_flag,
  output reg [4*DIGITS-1:0] present_count,
  output reg instruction_error_flag,
  output reg slot_conflict,
  // AXI4-Lite slave
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

  localparam PVW = 4*DIGITS;

  // Rising edge of a level against its last sampled value
  function is_rising;
    input now_lvl;
    input last_lvl;
    begin
      is_rising = now_lvl & ~last_lvl;
    end
  endfunction

  // Per-slot state; counts and history have no reset so they are retained
  reg [PVW-1:0] pv_mem [0:SLOTS-1];
  reg [SLOTS-1:0] flag_mem; // Completion flag per slot
  reg [SLOTS-1:0] mode_mem; // Operation of the slot's last execution
  reg [SLOTS-1:0] last_cnt_mem; // Count or up input at last execution
  reg [SLOTS-1:0] last_dn_mem; // Down input at last execution
  reg [SLOTS-1:0] last_rst_mem; // Reset input at last execution
  reg [SLOTS-1:0] claimed_r; // Slot already used since reset

  // Software-visible registers
  reg [31:0] ctrl_r;
  reg sticky_err_r;
  reg sticky_conflict_r;
  reg [SLOT_W-1:0] inspect_slot_r;
  reg [31:0] exec_count_r;

  // Current slot state as read from the arrays
  wire [PVW-1:0] pv_now = pv_mem[exec_slot];
  wire flag_now = flag_mem[exec_slot];
  wire last_cnt = last_cnt_mem[exec_slot];
  wire last_dn = last_dn_mem[exec_slot];
  wire last_rst = last_rst_mem[exec_slot];

  // Execution only while enabled from software
  wire exec_go = exec_strobe & ctrl_r[`CTRL_ENABLE_BIT];

  // Shared BCD steppers: one up, one down
  wire [PVW-1:0] pv_inc;
  wire [PVW-1:0] pv_dec;
  wire pv_is_bcd;
  wire pv_is_zero;
  wire preset_is_bcd;

  bcd_step #(.DIGITS(DIGITS)) u_step_up (
    .value(pv_now),
    .down(1'b0),
    .result(pv_inc),
    .is_bcd(pv_is_bcd),
    .is_zero(pv_is_zero)
  );

  bcd_step #(.DIGITS(DIGITS)) u_step_dn (
    .value(pv_now),
    .down(1'b1),
    .result(pv_dec),
    .is_bcd(),
    .is_zero()
  );

  // Validity test of the preset only
  bcd_step #(.DIGITS(DIGITS)) u_check_preset (
    .value(preset_limit),
    .down(1'b0),
    .result(),
    .is_bcd(preset_is_bcd),
    .is_zero()
  );

  // Next count and flag of the addressed slot
  reg [PVW-1:0] pv_nxt;
  reg flag_nxt;
  reg cnt_lvl;
  reg up_rise;
  reg dn_rise;
  reg rst_rise;

  always @* begin
    pv_nxt = pv_now;
    flag_nxt = flag_now;
    cnt_lvl = (exec_mode == `MODE_DOWN) ? count_pulse_input : count_up_input;
    up_rise = is_rising(cnt_lvl, last_cnt);
    dn_rise = is_rising(count_down_input, last_dn);
    rst_rise = is_rising(count_reset_input, last_rst);
    if (exec_mode == `MODE_DOWN) begin
      if (count_reset_input) begin
        // Reload on the reset edge, then hold while reset stays on
        if (rst_rise) begin
          pv_nxt = preset_limit;
        end
        flag_nxt = 1'b0;
      end else begin
        // Decrement stops at zero; flag follows zero
        if (up_rise && !pv_is_zero) begin
          pv_nxt = pv_dec;
        end
        flag_nxt = (pv_nxt == `PV_ZERO);
      end
    end else begin
      if (count_reset_input) begin
        // Reset clears; counting ignored while it is on
        if (rst_rise) begin
          pv_nxt = `PV_ZERO;
          flag_nxt = 1'b0;
        end
      end else if (up_rise && !dn_rise) begin
        // Going past preset wraps to zero
        if (pv_now >= preset_limit) begin
          pv_nxt = `PV_ZERO;
          flag_nxt = 1'b1;
        end else begin
          pv_nxt = pv_inc;
          flag_nxt = 1'b0;
        end
      end else if (dn_rise && !up_rise) begin
        // Going below zero wraps to preset
        if (pv_is_zero) begin
          pv_nxt = preset_limit;
          flag_nxt = 1'b1;
        end else begin
          pv_nxt = pv_dec;
          flag_nxt = 1'b0;
        end
      end
      // Both or neither rising: nothing changes
    end
  end

  // Error and conflict for this execution
  wire exec_err = ~preset_is_bcd | operand_fault | ~pv_is_bcd;
  wire exec_conflict = claimed_r[exec_slot] & (mode_mem[exec_slot] != exec_mode);

  // Slot arrays; no reset so interlock and power loss keep counts
  always @(posedge clk_sys) begin
    if (exec_go) begin
      pv_mem[exec_slot] <= pv_nxt;
      flag_mem[exec_slot] <= flag_nxt;
      mode_mem[exec_slot] <= exec_mode;
      last_cnt_mem[exec_slot] <= cnt_lvl;
      last_dn_mem[exec_slot] <= count_down_input;
      last_rst_mem[exec_slot] <= count_reset_input;
    end
  end

  // Claim tracking, cleared by reset only
  always @(posedge clk_sys) begin
    if (!rstn) begin
      claimed_r <= {SLOTS{1'b0}};
    end else if (exec_go) begin
      claimed_r[exec_slot] <= 1'b1;
    end
  end

  // Result outputs of the execution port
  always @(posedge clk_sys) begin
    if (!rstn) begin
      exec_done <= 1'b0;
      done_flag <= 1'b0;
      present_count <= `PV_ZERO;
      instruction_error_flag <= 1'b0;
      slot_conflict <= 1'b0;
      exec_count_r <= 32'h0000_0000;
    end else begin
      exec_done <= exec_go;
      if (exec_go) begin
        // Execution proceeds even when the error is raised
        done_flag <= flag_nxt;
        present_count <= pv_nxt;
        instruction_error_flag <= exec_err;
        slot_conflict <= exec_conflict;
        exec_count_r <= exec_count_r + 32'h0000_0001;
      end
    end
  end

  // AXI write channel holding registers
  reg aw_held_r;
  reg w_held_r;
  reg [7:0] aw_addr_r;
  reg [31:0] w_data_r;
  reg [3:0] w_strb_r;

  assign s_axi_awready = ~aw_held_r & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held_r & ~s_axi_bvalid;

  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire aw_have = aw_held_r | aw_take;
  wire w_have = w_held_r | w_take;
  wire [7:0] wr_addr = aw_held_r ? aw_addr_r : s_axi_awaddr;
  wire [31:0] wr_data = w_held_r ? w_data_r : s_axi_wdata;
  wire [3:0] wr_strb = w_held_r ? w_strb_r : s_axi_wstrb;
  wire wr_fire = aw_have & w_have & ~s_axi_bvalid;

  // Known writable address decode
  wire wr_mapped = (wr_addr == `REG_CTRL) | (wr_addr == `REG_STATUS) |
                   (wr_addr == `REG_INSPECT_SLOT);

  // Status clear pulse; hardware set wins over clear
  wire clr_err = wr_fire & (wr_addr == `REG_STATUS) & wr_strb[0] & wr_data[`STAT_ERROR_BIT];
  wire clr_cfl = wr_fire & (wr_addr == `REG_STATUS) & wr_strb[0] &
                 wr_data[`STAT_CONFLICT_BIT];

  // Write path: capture, commit, respond
  always @(posedge clk_sys) begin
    if (!rstn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      ctrl_r <= `CTRL_RESET;
      inspect_slot_r <= {SLOT_W{1'b0}};
    end else begin
      if (aw_take) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (w_take) begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
        if (wr_addr == `REG_CTRL && wr_strb[0]) begin
          ctrl_r[7:0] <= wr_data[7:0];
        end
        if (wr_addr == `REG_INSPECT_SLOT) begin
          if (wr_strb[0]) begin
            inspect_slot_r[7:0] <= wr_data[7:0];
          end
          if (wr_strb[1]) begin
            inspect_slot_r[SLOT_W-1:8] <= wr_data[SLOT_W-1:8];
          end
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Sticky status bits
  always @(posedge clk_sys) begin
    if (!rstn) begin
      sticky_err_r <= 1'b0;
      sticky_conflict_r <= 1'b0;
    end else begin
      sticky_err_r <= (exec_go & exec_err) | (sticky_err_r & ~clr_err);
      sticky_conflict_r <= (exec_go & exec_conflict) | (sticky_conflict_r & ~clr_cfl);
    end
  end

  // Read path: one request at a time, answer next cycle
  assign s_axi_arready = ~s_axi_rvalid;
  wire [PVW-1:0] insp_pv = pv_mem[inspect_slot_r];
  reg [31:0] rd_word;
  reg rd_ok;

  always @* begin
    rd_word = 32'h0000_0000;
    rd_ok = 1'b1;
    case (s_axi_araddr)
      `REG_CTRL: begin
        rd_word = ctrl_r;
      end
      `REG_STATUS: begin
        rd_word[`STAT_ERROR_BIT] = sticky_err_r;
        rd_word[`STAT_CONFLICT_BIT] = sticky_conflict_r;
      end
      `REG_INSPECT_SLOT: begin
        rd_word[SLOT_W-1:0] = inspect_slot_r;
      end
      `REG_INSPECT_DATA: begin
        rd_word[PVW-1:0] = insp_pv;
        rd_word[`INSP_CLAIMED_BIT] = claimed_r[inspect_slot_r];
        rd_word[`INSP_FLAG_BIT] = flag_mem[inspect_slot_r];
        rd_word[`INSP_MODE_BIT] = mode_mem[inspect_slot_r];
      end
      `REG_EXEC_COUNT: begin
        rd_word = exec_count_r;
      end
      default: begin
        // Unmapped reads give zero with an error response
        rd_ok = 1'b0;
      end
    endcase
  end

  // Read data register
  always @(posedge clk_sys) begin
    if (!rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// [test/bcd_counter_properties.sv]
// Concurrent checks on the counter bank execution port.
// Assumes one clock and synchronous active-low reset.
module bcd_counter_properties (
  input wire clk_sys,
  input wire rstn,
  input wire exec_strobe,
  input wire exec_mode,
  input wire count_reset_input,
  input wire [15:0] preset_limit,
  input wire operand_fault,
  input wire exec_done,
  input wire done_flag,
  input wire [15:0] present_count,
  input wire instruction_error_flag
);
  // Single domain
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  chk_done_cause: assert property (exec_done |-> $past(exec_strobe))
    else $error("done without strobe");
  chk_err_preset: assert property (exec_strobe && preset_limit[3:0] > 4'h9
    |=> !exec_done || instruction_error_flag) else $error("bad preset not flagged");
  chk_err_fault: assert property (exec_strobe && operand_fault
    |=> !exec_done || instruction_error_flag) else $error("fault not flagged");
  // Error-free results must stay four BCD digits
  chk_count_bcd: assert property (exec_done && !instruction_error_flag |->
    present_count[15:12] <= 4'h9 && present_count[11:8] <= 4'h9 &&
    present_count[7:4] <= 4'h9 && present_count[3:0] <= 4'h9) else $error("count not BCD");
  chk_down_rst_flag: assert property (exec_strobe && !exec_mode && count_reset_input
    |=> !exec_done || !done_flag) else $error("flag during reset");
  chk_down_zero: assert property (exec_done && !instruction_error_flag &&
    !$past(exec_mode) && !$past(count_reset_input) |-> done_flag == (present_count == 16'h0000))
    else $error("flag not tied to zero");
  chk_rev_rst_hold: assert property (exec_strobe && exec_mode && count_reset_input
    |=> !exec_done || (present_count == 16'h0000 && !done_flag)) else $error("count in reset");
  chk_rev_range: assert property (exec_done && !instruction_error_flag &&
    $past(exec_mode) |-> present_count <= $past(preset_limit)) else $error("count past preset");
endmodule

bind bcd_updown_counter bcd_counter_properties u_props (.*);

// [test/seq_model.sv]
// Sequencer stand-in: one execution of one slot per call.
// Assumes the bank answers one cycle after the strobe edge.
module seq_model (
  input wire logic clk_sys,
  output logic exec_strobe,
  output logic [8:0] exec_slot,
  output logic exec_mode,
  output logic count_pulse_input,
  output logic count_up_input,
  output logic count_down_input,
  output logic count_reset_input,
  output logic [15:0] preset_limit,
  output logic operand_fault
);
  timeunit 1ns;
  timeprecision 1ns;
  // Quiet at time zero
  initial begin
    exec_strobe = 1'b0;
    {exec_slot, exec_mode, preset_limit, operand_fault} = '0;
    {count_pulse_input, count_up_input, count_down_input, count_reset_input} = '0;
  end
  // Levels hold for the whole execution, never a short pulse
  task automatic run(input logic [8:0] s, input logic m, input logic [3:0] c,
                     input logic [15:0] p, input logic f);
    @(posedge clk_sys);
    exec_strobe <= 1'b1;
    exec_slot <= s;
    exec_mode <= m;
    count_reset_input <= c[2];
    count_pulse_input <= c[1];
    count_up_input <= c[1];
    count_down_input <= c[0];
    preset_limit <= p;
    operand_fault <= f;
    @(posedge clk_sys);
    exec_strobe <= 1'b0;
    // Scramble released operands so stale values cannot pass
    {exec_slot, exec_mode, preset_limit, operand_fault} <= ~{s, m, p, f};
    #1;
  endtask
endmodule

// [test/tb.sv]
// Self-checking bench for the BCD counter bank.
// Assumes seq_model for executions; registers over AXI4-Lite.
`include "bcd_counter_defines.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic exec_strobe, exec_mode, count_pulse_input, count_up_input, count_down_input;
  logic count_reset_input, operand_fault, exec_done, done_flag;
  logic instruction_error_flag, slot_conflict;
  logic [8:0] exec_slot;
  logic [15:0] preset_limit, present_count;
  int mismatches = 0;
  int num_checks = 0;
  // Step: {mode,reset,up/count,down}, expected count, expected flag (F unchecked)
  logic [23:0] tbl [33] = '{
    24'h0_0000_F, 24'h4_0003_0, 24'h6_0003_0, 24'h0_0003_0, 24'h2_0002_0,
    24'h2_0002_0, 24'h0_0002_0, 24'h2_0001_0, 24'h0_0001_0, 24'h2_0000_1,
    24'h0_0000_1, 24'h2_0000_1, 24'h4_0003_0,
    24'h8_0000_F, 24'hC_0000_0, 24'h8_0000_0, 24'h9_0010_1, 24'h8_0010_1,
    24'h9_0009_0, 24'h8_0009_0, 24'hA_0010_0, 24'h8_0010_0, 24'hA_0000_1,
    24'h8_0000_1, 24'hB_0000_1, 24'h8_0000_1, 24'hA_0001_0, 24'h8_0001_0,
    24'hE_0000_0, 24'hC_0000_0, 24'hE_0000_0, 24'h8_0000_0, 24'hA_0001_0};
  bcd_updown_counter u_dut (.*);
  seq_model u_seq (.*);
  always #25 clk_sys = ~clk_sys;
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wrap_up;
    if (mismatches == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Address and data offered together, each released when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(r));
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, d);
    chk(32'(s_axi_rresp), 32'(r));
  endtask
  // Hang guard at 4000 cycles, far beyond the expected run of about 140 cycles
  initial begin
    #200000;
    mismatches++;
    wrap_up;
  end
  initial begin
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    axi_rd(`REG_CTRL, `CTRL_RESET, `RESP_OKAY);
    // Down slot 4 with preset 3, reversible slot 7 with preset 10
    foreach (tbl[i]) begin
      u_seq.run(tbl[i][23] ? 9'h007 : 9'h004, tbl[i][23], tbl[i][23:20],
                tbl[i][23] ? 16'h0010 : 16'h0003, 1'b0);
      chk(32'(exec_done), 32'h1);
      if (tbl[i][3:0] != 4'hF) begin
        chk(32'(present_count), 32'(tbl[i][19:4]));
        chk(32'(done_flag), 32'(tbl[i][3:0]));
      end
    end
    axi_wr(`REG_INSPECT_SLOT, 32'h0000_0007, `RESP_OKAY);
    axi_rd(`REG_INSPECT_DATA, 32'h0005_0001, `RESP_OKAY);
    // Dropped strobe must leave the input history alone
    axi_wr(`REG_CTRL, 32'h0000_0000, `RESP_OKAY);
    u_seq.run(9'h007, 1'b1, 4'h8, 16'h0010, 1'b0);
    chk(32'(exec_done), 32'h0);
    axi_wr(`REG_CTRL, `CTRL_RESET, `RESP_OKAY);
    @(posedge clk_sys);
    rstn <= 1'b0;
    @(posedge clk_sys);
    rstn <= 1'b1;
    axi_rd(`REG_EXEC_COUNT, 32'h0000_0000, `RESP_OKAY);
    u_seq.run(9'h007, 1'b1, 4'hA, 16'h0010, 1'b0);
    chk(32'(present_count), 32'h0000_0001);
    axi_rd(`REG_EXEC_COUNT, 32'h0000_0001, `RESP_OKAY);
    u_seq.run(9'h004, 1'b0, 4'h4, 16'h00A0, 1'b0);
    chk(32'(instruction_error_flag), 32'h1);
    u_seq.run(9'h004, 1'b0, 4'h4, 16'h0003, 1'b1);
    chk(32'(instruction_error_flag), 32'h1);
    u_seq.run(9'h004, 1'b1, 4'h8, 16'h0010, 1'b0);
    chk(32'(slot_conflict), 32'h1);
    chk(32'(present_count), 32'h0000_0003);
    axi_rd(`REG_STATUS, 32'h0000_0003, `RESP_OKAY);
    axi_wr(`REG_STATUS, 32'h0000_0003, `RESP_OKAY);
    axi_rd(`REG_STATUS, 32'h0000_0000, `RESP_OKAY);
    axi_wr(`REG_EXEC_COUNT, 32'h0000_0001, `RESP_SLVERR);
    axi_rd(8'h20, 32'h0000_0000, `RESP_SLVERR);
    // Fresh slots 5 and 6: first pass with all inputs off seeds the history
    u_seq.run(9'h005, 1'b0, 4'h0, 16'h0001, 1'b0);
    u_seq.run(9'h006, 1'b0, 4'h0, 16'h0002, 1'b0);
    u_seq.run(9'h006, 1'b0, 4'h4, 16'h0002, 1'b0);
    u_seq.run(9'h006, 1'b0, 4'h0, 16'h0002, 1'b0);
    chk(32'(present_count), 32'h0000_0002);
    u_seq.run(9'h005, 1'b0, 4'h4, 16'h0001, 1'b0);
    u_seq.run(9'h005, 1'b0, 4'h0, 16'h0001, 1'b0);
    u_seq.run(9'h005, 1'b0, 4'h2, 16'h0001, 1'b0);
    chk(32'(done_flag), 32'h1);
    // Slot 5 flag wired back to its own reset input
    u_seq.run(9'h005, 1'b0, 4'h6, 16'h0001, 1'b0);
    chk(32'(present_count), 32'h0000_0001);
    chk(32'(done_flag), 32'h0);
    // Rise of slot 5 flag used as slot 6 count input
    u_seq.run(9'h006, 1'b0, 4'h2, 16'h0002, 1'b0);
    chk(32'(present_count), 32'h0000_0001);
    wrap_up;
  end
endmodule
